// ===== power_master_unit_pkg.sv
// Purpose: Shared constants and types for the power state master control block.
// Assumes: 8-bit register port, 200 MHz REF_CLK.
// Notes:   Offsets are the register addresses of the power master unit.
package power_master_unit_pkg;

  localparam logic [7:0] OFS_P1_EVENTS   = 8'h46;
  localparam logic [7:0] OFS_P2_EVENTS   = 8'h47;
  localparam logic [7:0] OFS_P3_EVENTS   = 8'h48;
  localparam logic [7:0] OFS_SEQ_STATE   = 8'h49;
  localparam logic [7:0] OFS_BUS_CFG     = 8'h4a;
  localparam logic [7:0] OFS_WORD_HIGH   = 8'h4b;
  localparam logic [7:0] OFS_WORD_LOW    = 8'h4c;
  localparam logic [7:0] OFS_DEBOUNCE    = 8'h51;
  localparam logic [7:0] OFS_W2P_POINTER = 8'h52;
  localparam logic [7:0] OFS_P2A_POINTER = 8'h53;
  localparam logic [7:0] OFS_HW_STATUS   = 8'h45;

  // Event register fields
  localparam int BIT_OFF_TRIG     = 0;
  localparam int BIT_SLEEP_TRIG   = 1;
  localparam int BIT_ACTIVE_TRIG  = 2;
  localparam int BIT_LEVEL_SLEEP  = 3;
  localparam int BIT_WARM_ENABLE  = 4;
  localparam int BIT_SYSLINE_RST  = 5;
  localparam int BIT_LONG_PRESS   = 6;
  // Hardware status fields
  localparam int BIT_BUTTON       = 0;
  localparam int BIT_USB          = 2;
  localparam int BIT_SOFT_RESET   = 3;
  localparam int BIT_WAKE1        = 4;
  localparam int BIT_WAKE3        = 6;
  localparam int BIT_VBUS         = 7;
  // State and bus config fields
  localparam int BIT_IDLE         = 6;
  localparam int BIT_PENDING      = 0;
  localparam int BIT_HOST_SHARE   = 1;
  localparam int POS_SHARE_SEL    = 2;

  localparam logic       RST_LONG_PRESS = 1'b1;
  localparam logic [7:0] RST_WORD_BYTE  = 8'hff;
  localparam logic [2:0] RST_DEB_CODE   = 3'h2;
  localparam logic [5:0] RST_W2P_PTR    = 6'h00;
  localparam logic [5:0] RST_P2A_PTR    = 6'h04;

  localparam int CLK_MHZ        = 200;
  localparam int LONG_PRESS_S   = 8;
  localparam int BTN_DEB_US     = 30000;
  localparam longint LONG_PRESS_CYC = longint'(LONG_PRESS_S) * 64'd1000000 * CLK_MHZ;
  localparam int BTN_DEB_CYC    = BTN_DEB_US * CLK_MHZ;
  localparam int DEB_MS_TABLE [8] = '{0, 14, 28, 42, 70, 93, 140, 233};
  localparam int CYC_PER_MS     = CLK_MHZ * 1000;

  typedef enum logic [1:0] {ST_WAITON, ST_ACTIVE, ST_SLEEP, ST_OTHER} seq_code_t;

  typedef struct packed {
    logic go_active;
    logic go_sleep;
    logic go_off;
  } trig_t;

  typedef struct packed {
    logic [1:0] share_sel;
    logic       host_share;
  } bus_cfg_t;

  function automatic logic [31:0] deb_cycles(input logic [2:0] code, input int per_ms);
    deb_cycles = 32'(DEB_MS_TABLE[code] * per_ms);
  endfunction : deb_cycles

endpackage : power_master_unit_pkg

// ===== pin_filter.sv
// Purpose: Three-stage synchroniser plus hold-time filter for one pin.
// Assumes: Pin is asynchronous to clk.
// Notes:   A hold of zero passes the synchronised level at once.
module pin_filter
  import power_master_unit_pkg::*;
#(
  parameter logic INIT = 1'b0
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        pin,
  input  wire logic [31:0] hold,
  output logic             level
);
  logic        s1_q, s2_q, s3_q;
  logic [31:0] cnt_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      s1_q <= INIT;
      s2_q <= INIT;
      s3_q <= INIT;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Level changes once stages two and three agree for the hold time
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= 32'h0;
      level <= INIT;
    end else if (s2_q != s3_q || s3_q == level) begin
      cnt_q <= 32'h0;
    end else if (cnt_q >= hold) begin
      cnt_q <= 32'h0;
      level <= s3_q;
    end else begin
      cnt_q <= cnt_q + 32'h1;
    end
  end
endmodule : pin_filter

// ===== seq_tracker.sv
// Purpose: State tracker for one processor's power sequencer.
// Assumes: Transition length is a fixed count standing in for the step memory.
// Notes:   Reports WaitOn/Active/Sleep/other and a busy flag.
module seq_tracker
  import power_master_unit_pkg::*;
#(
  parameter int STEPS = 16
) (
  input  wire logic  clk,
  input  wire logic  rst,
  input  trig_t      trig,
  input  wire logic  level_mode,
  input  wire logic  sleep_line,
  output seq_code_t  code,
  output logic       busy
);
  typedef enum logic [2:0] {WAITON, ACTIVE, SLEEP, TO_ACTIVE, TO_SLEEP, TO_OFF} st_t;
  st_t         st_q;
  logic [15:0] cnt_q;
  logic        line_q;
  logic        rise, fall;

  assign rise = sleep_line & ~line_q;
  assign fall = ~sleep_line & line_q;

  always_ff @(posedge clk) begin
    if (rst) line_q <= 1'b0;
    else     line_q <= sleep_line;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q  <= WAITON;
      cnt_q <= 16'h0;
    end else begin
      case (st_q)
        WAITON: if (trig.go_active) st_q <= TO_ACTIVE;
        ACTIVE: begin
          if (trig.go_off) st_q <= TO_OFF;
          else if (trig.go_sleep || (level_mode && fall)) st_q <= TO_SLEEP; // R11 R12
        end
        SLEEP: begin
          if (trig.go_off) st_q <= TO_OFF;
          else if (trig.go_active || rise) st_q <= TO_ACTIVE; // R11 R12
        end
        TO_ACTIVE, TO_SLEEP, TO_OFF: begin
          if (cnt_q == 16'(STEPS - 1)) begin
            cnt_q <= 16'h0;
            st_q  <= (st_q == TO_ACTIVE) ? ACTIVE : (st_q == TO_SLEEP) ? SLEEP : WAITON;
          end else begin
            cnt_q <= cnt_q + 16'h1;
          end
        end
        default: st_q <= WAITON;
      endcase
    end
  end

  always_comb begin
    busy = 1'b0;
    case (st_q)
      WAITON:  code = ST_WAITON;
      ACTIVE:  code = ST_ACTIVE;
      SLEEP:   code = ST_SLEEP;
      default: begin
        code = ST_OTHER;
        busy = 1'b1;
      end
    endcase
  end
endmodule : seq_tracker

// ===== power_master_unit_ctrl.sv
// Purpose: Power state master control: status, software events, bus arbitration.
// Assumes: Byte register port with one-cycle write/read strobes, clocked by REF_CLK.
// Notes:   Read data is registered and appears one cycle after the read strobe.
// Summary of operation
// R1 - Status shows live vbus, usb, wake levels; vbus there is the debounced level set by the debounce code
// R2 - Status bit 3 set while warm pin low
// R3 - Status bit 0 is debounced button level
// R4 - Bit 2 write starts activate, self clears
// R5 - Bit 1 write starts sleep, self clears
// R6 - Bit 0 write starts off, self clears
// R7 - Long button press restarts when option set
// R8 - Restart options shared across three event registers
// R9 - Bit 5 enables reset on system line low
// R10 - Bit 4 enables warm reset for all
// R11 - Level bit clear: only rising edge wakes
// R12 - Level bit set: line level selects state
// R13 - Third sleep line is clock request input
// R14 - Idle flag set when no sequencer transitions
// R15 - Two-bit state code per sequencer
// R16 - Share select arbitrates power bus slots
// R17 - Host share bit grants slots to host
// R18 - Pending flag while queued word unsent
// R19 - Low byte write queues word, bytes reset ones
// R20 - Debounce code selects vbus/id debounce time
// R21 - Key lock gates debounce and pointer writes
// R22 - Six-bit start pointers, first resets zero
// R23 - Locked bits stay readable, writes ignored
// R24 - Word sent high byte first in msb
module power_master_unit_ctrl
  import power_master_unit_pkg::*;
#(
  parameter longint LONG_PRESS_CYCLES = LONG_PRESS_CYC,
  parameter int     BUTTON_DEB_CYCLES = BTN_DEB_CYC,
  parameter int     DEB_PER_MS        = CYC_PER_MS,
  parameter int     SEQ_STEPS         = 16
) (
  input  wire logic        REF_CLK,
  input  wire logic        RESET,
  input  wire logic [7:0]  REG_ADDR,
  input  wire logic [7:0]  REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic [7:0]       REG_RDATA,
  input  wire logic        CFG_KEY_OPEN,
  input  wire logic        VBUS_PIN,
  input  wire logic        ID_PIN,
  input  wire logic        USB_PIN,
  input  wire logic        FIRST_SLEEP_REQUEST,
  input  wire logic        CLOCK_REQUEST_INPUT,
  input  wire logic        WARM_RESET_N,
  input  wire logic        POWER_BUTTON_N,
  input  wire logic        SYSTEM_ENABLE_LINE,
  output logic             DEVICE_RESTART,
  output logic             WARM_RESET_ENABLE,
  output logic             VBUS_DEBOUNCED,
  output logic             ID_DEBOUNCED,
  output logic [15:0]      BUS_WORD,
  output logic             BUS_WORD_VALID,
  input  wire logic        BUS_WORD_TAKEN,
  output logic [1:0]       BUS_GRANT,
  output logic [5:0]       W2P_POINTER,
  output logic [5:0]       P2A_POINTER
);
  // Grant codes: sequencer 1..3, 0 = host
  localparam logic [1:0] GRANT_HOST = 2'h0;

  logic        long_press_q, sysline_rst_q, warm_en_q;
  logic [2:0]  level_q;
  bus_cfg_t    bus_cfg_q;
  logic [7:0]  word_hi_q, word_lo_q;
  logic        pending_q;
  logic [2:0]  deb_code_q;
  logic [5:0]  w2p_q, p2a_q;
  trig_t       trig [3];
  seq_code_t   code [3];
  logic [2:0]  busy;
  logic        vbus_lvl, id_lvl, usb_lvl, wake1_lvl, wake3_lvl, warm_n_lvl;
  logic        button_lvl, system_enable_line_lvl;
  logic [31:0] deb_hold;
  logic [35:0] press_q;
  logic        system_enable_line_prev_q;
  logic [7:0]  hw_status, ev_read, state_read, cfg_read;
  logic [3:0]  slot_q;
  logic        wr_ev;

  assign deb_hold = deb_cycles(deb_code_q, DEB_PER_MS); // R20
  assign wr_ev = REG_WR && (REG_ADDR == OFS_P1_EVENTS || REG_ADDR == OFS_P2_EVENTS
                 || REG_ADDR == OFS_P3_EVENTS);

  pin_filter u_vbus  (.clk(REF_CLK), .rst(RESET), .pin(VBUS_PIN), .hold(deb_hold),
                      .level(vbus_lvl));
  pin_filter u_id    (.clk(REF_CLK), .rst(RESET), .pin(ID_PIN), .hold(deb_hold),
                      .level(id_lvl));
  pin_filter u_usb   (.clk(REF_CLK), .rst(RESET), .pin(USB_PIN), .hold(32'h0),
                      .level(usb_lvl));
  pin_filter u_wake1 (.clk(REF_CLK), .rst(RESET), .pin(FIRST_SLEEP_REQUEST), .hold(32'h0),
                      .level(wake1_lvl));
  pin_filter u_wake3 (.clk(REF_CLK), .rst(RESET), .pin(CLOCK_REQUEST_INPUT), .hold(32'h0),
                      .level(wake3_lvl));
  pin_filter #(.INIT(1'b1)) u_warm (.clk(REF_CLK), .rst(RESET), .pin(WARM_RESET_N),
                      .hold(32'h0), .level(warm_n_lvl));
  pin_filter u_btn   (.clk(REF_CLK), .rst(RESET), .pin(~POWER_BUTTON_N),
                      .hold(32'(BUTTON_DEB_CYCLES)), .level(button_lvl)); // R3
  pin_filter #(.INIT(1'b1)) u_system_enable_line (.clk(REF_CLK), .rst(RESET), .pin(SYSTEM_ENABLE_LINE),
                      .hold(32'h0), .level(system_enable_line_lvl));

  // Shared option bits: any of the three event registers updates them
  always_ff @(posedge REF_CLK) begin
    if (RESET || DEVICE_RESTART) begin
      long_press_q  <= RST_LONG_PRESS;
      sysline_rst_q <= 1'b0;
      warm_en_q     <= 1'b0;
    end else if (wr_ev) begin
      long_press_q  <= REG_WDATA[BIT_LONG_PRESS]; // R8
      sysline_rst_q <= REG_WDATA[BIT_SYSLINE_RST]; // R8
      warm_en_q     <= REG_WDATA[BIT_WARM_ENABLE]; // R10
    end
  end

  // Level wake-up is per processor; the second has no sleep line
  always_ff @(posedge REF_CLK) begin
    if (RESET || DEVICE_RESTART) begin
      level_q <= 3'h0;
    end else if (REG_WR) begin
      if (REG_ADDR == OFS_P1_EVENTS) level_q[0] <= REG_WDATA[BIT_LEVEL_SLEEP];
      if (REG_ADDR == OFS_P2_EVENTS) level_q[1] <= REG_WDATA[BIT_LEVEL_SLEEP]; // R13
      if (REG_ADDR == OFS_P3_EVENTS) level_q[2] <= REG_WDATA[BIT_LEVEL_SLEEP];
    end
  end

  // Triggers are single-cycle pulses, never stored, so they read back zero
  generate
    for (genvar p = 0; p < 3; p++) begin : g_seq
      logic hit;
      logic line;
      assign hit  = REG_WR && (REG_ADDR == 8'(OFS_P1_EVENTS + 8'(p)));
      assign trig[p].go_active = hit & REG_WDATA[BIT_ACTIVE_TRIG]; // R4
      assign trig[p].go_sleep  = hit & REG_WDATA[BIT_SLEEP_TRIG];  // R5
      assign trig[p].go_off    = hit & REG_WDATA[BIT_OFF_TRIG];    // R6
      assign line = (p == 0) ? wake1_lvl : (p == 2) ? wake3_lvl : 1'b0; // R13
      seq_tracker #(.STEPS(SEQ_STEPS)) u_seq (
        .clk        (REF_CLK),
        .rst        (RESET || DEVICE_RESTART),
        .trig       (trig[p]),
        .level_mode (level_q[p]),
        .sleep_line (line),
        .code       (code[p]),
        .busy       (busy[p])
      );
    end
  endgenerate

  // Long press counter and system line reset
  always_ff @(posedge REF_CLK) begin
    if (RESET || DEVICE_RESTART) begin
      press_q      <= 36'h0;
      system_enable_line_prev_q <= 1'b1;
    end else begin
      system_enable_line_prev_q <= system_enable_line_lvl;
      if (!button_lvl)
        press_q <= 36'h0;
      else if (press_q < 36'(LONG_PRESS_CYCLES))
        press_q <= press_q + 36'h1;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET || DEVICE_RESTART) begin
      DEVICE_RESTART <= 1'b0;
    end else begin
      DEVICE_RESTART <= (long_press_q && press_q == 36'(LONG_PRESS_CYCLES) - 36'h1) // R7
                        || (sysline_rst_q && system_enable_line_prev_q && !system_enable_line_lvl); // R9
    end
  end

  // Bus config and queued word
  always_ff @(posedge REF_CLK) begin
    if (RESET || DEVICE_RESTART) begin
      bus_cfg_q <= '0;
    end else if (REG_WR && REG_ADDR == OFS_BUS_CFG) begin
      bus_cfg_q.share_sel  <= REG_WDATA[POS_SHARE_SEL +: 2]; // R16
      bus_cfg_q.host_share <= REG_WDATA[BIT_HOST_SHARE]; // R17
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET || DEVICE_RESTART) begin
      word_hi_q <= RST_WORD_BYTE; // R19
      word_lo_q <= RST_WORD_BYTE; // R19
    end else if (REG_WR) begin
      if (REG_ADDR == OFS_WORD_HIGH) word_hi_q <= REG_WDATA;
      if (REG_ADDR == OFS_WORD_LOW)  word_lo_q <= REG_WDATA;
    end
  end

  // Word leaves only in a host slot; a new low write while pending wins
  always_ff @(posedge REF_CLK) begin
    if (RESET || DEVICE_RESTART) begin
      pending_q <= 1'b0;
      BUS_WORD  <= {RST_WORD_BYTE, RST_WORD_BYTE};
    end else if (REG_WR && REG_ADDR == OFS_WORD_LOW) begin
      pending_q <= 1'b1; // R19 R18
      BUS_WORD  <= {word_hi_q, REG_WDATA}; // R24
    end else if (BUS_WORD_VALID && BUS_WORD_TAKEN) begin
      pending_q <= 1'b0; // R18
    end
  end

  // Sixteen-slot round: share select owns the even slots, or the three rotate in turn
  always_ff @(posedge REF_CLK) begin
    if (RESET || DEVICE_RESTART) slot_q <= 4'h0;
    else                         slot_q <= slot_q + 4'h1;
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET || DEVICE_RESTART) begin
      BUS_GRANT      <= 2'h1;
      BUS_WORD_VALID <= 1'b0;
    end else begin
      BUS_GRANT      <= grant_of(slot_q, bus_cfg_q); // R16 R17
      BUS_WORD_VALID <= pending_q && grant_of(slot_q, bus_cfg_q) == GRANT_HOST
                        && !(BUS_WORD_VALID && BUS_WORD_TAKEN);
    end
  end

  function automatic logic [1:0] grant_of(input logic [3:0] s, input bus_cfg_t c);
    logic [1:0] other;
    other = 2'h0;
    if (c.share_sel == 2'h0) begin
      if (c.host_share) grant_of = (s[1:0] == 2'h3) ? GRANT_HOST : 2'(s[1:0] + 2'h1);
      else              grant_of = 2'(s % 4'h3) + 2'h1;
    end else if (s[0] == 1'b0) begin
      grant_of = c.share_sel;
    end else begin
      // Odd slots alternate the two others; host share takes half of the second one's slots
      other = (s[1] == 1'b0) ? ((c.share_sel == 2'h1) ? 2'h2 : 2'h1)
                             : ((c.share_sel == 2'h3) ? 2'h2 : 2'h3);
      grant_of = (c.host_share && s[2:1] == 2'h3) ? GRANT_HOST
               : other; // R16
    end
  endfunction : grant_of

  // Key-protected configuration
  always_ff @(posedge REF_CLK) begin
    if (RESET || DEVICE_RESTART) begin
      deb_code_q <= RST_DEB_CODE; // R20
      w2p_q      <= RST_W2P_PTR; // R22
      p2a_q      <= RST_P2A_PTR;
    end else if (REG_WR && CFG_KEY_OPEN) begin // R21 R23
      if (REG_ADDR == OFS_DEBOUNCE)    deb_code_q <= REG_WDATA[2:0];
      if (REG_ADDR == OFS_W2P_POINTER) w2p_q      <= REG_WDATA[5:0]; // R22
      if (REG_ADDR == OFS_P2A_POINTER) p2a_q      <= REG_WDATA[5:0];
    end
  end

  always_comb begin
    hw_status = 8'h0;
    hw_status[BIT_VBUS]       = vbus_lvl; // R1
    hw_status[BIT_WAKE3]      = wake3_lvl; // R1
    hw_status[BIT_WAKE1]      = wake1_lvl; // R1
    hw_status[BIT_USB]        = usb_lvl; // R1
    hw_status[BIT_SOFT_RESET] = ~warm_n_lvl; // R2
    hw_status[BIT_BUTTON]     = button_lvl; // R3
    ev_read = 8'h0;
    ev_read[BIT_LONG_PRESS]  = long_press_q; // R8
    ev_read[BIT_SYSLINE_RST] = sysline_rst_q;
    ev_read[BIT_WARM_ENABLE] = warm_en_q;
    state_read = {1'b0, ~|busy, code[2], code[1], code[0]}; // R14 R15
    cfg_read   = {4'h0, bus_cfg_q.share_sel, bus_cfg_q.host_share, pending_q};
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      REG_RDATA <= 8'h0;
    end else if (REG_RD) begin
      case (REG_ADDR)
        OFS_HW_STATUS:   REG_RDATA <= hw_status;
        OFS_P1_EVENTS:   REG_RDATA <= ev_read | {4'h0, level_q[0], 3'h0};
        OFS_P2_EVENTS:   REG_RDATA <= ev_read | {4'h0, level_q[1], 3'h0};
        OFS_P3_EVENTS:   REG_RDATA <= ev_read | {4'h0, level_q[2], 3'h0};
        OFS_SEQ_STATE:   REG_RDATA <= state_read;
        OFS_BUS_CFG:     REG_RDATA <= cfg_read;
        OFS_WORD_HIGH:   REG_RDATA <= word_hi_q;
        OFS_WORD_LOW:    REG_RDATA <= word_lo_q;
        OFS_DEBOUNCE:    REG_RDATA <= {5'h0, deb_code_q}; // R23
        OFS_W2P_POINTER: REG_RDATA <= {2'h0, w2p_q};
        OFS_P2A_POINTER: REG_RDATA <= {2'h0, p2a_q};
        default:         REG_RDATA <= 8'h0;
      endcase
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      WARM_RESET_ENABLE <= 1'b0;
      VBUS_DEBOUNCED    <= 1'b0;
      ID_DEBOUNCED      <= 1'b0;
      W2P_POINTER       <= RST_W2P_PTR;
      P2A_POINTER       <= RST_P2A_PTR;
    end else begin
      WARM_RESET_ENABLE <= warm_en_q; // R10
      VBUS_DEBOUNCED    <= vbus_lvl;
      ID_DEBOUNCED      <= id_lvl;
      W2P_POINTER       <= w2p_q;
      P2A_POINTER       <= p2a_q;
    end
  end

  property p_trig_self_clear;
    @(posedge REF_CLK) disable iff (RESET)
      (REG_RD && REG_ADDR == OFS_P1_EVENTS) |=> (REG_RDATA[2:0] == 3'h0);
  endproperty
  trig_clear_a: assert property (p_trig_self_clear) else $error("trigger bits read nonzero"); // R4
  sleep_start_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    (trig[0].go_sleep && code[0] == ST_ACTIVE && !trig[0].go_off) |=> busy[0])
    else $error("sleep trigger ignored"); // R5
  off_start_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    (trig[0].go_off && code[0] == ST_SLEEP) |=> busy[0])
    else $error("off trigger ignored"); // R6
  shared_opt_a: assert property (@(posedge REF_CLK) disable iff (RESET || DEVICE_RESTART)
    (REG_WR && REG_ADDR == OFS_P3_EVENTS) |=> long_press_q == $past(REG_WDATA[6]))
    else $error("shared option not updated"); // R8
  key_lock_a: assert property (@(posedge REF_CLK) disable iff (RESET || DEVICE_RESTART)
    (REG_WR && !CFG_KEY_OPEN) |=> $stable(deb_code_q) && $stable(w2p_q))
    else $error("locked register changed"); // R21
  pending_set_a: assert property (@(posedge REF_CLK) disable iff (RESET || DEVICE_RESTART)
    (REG_WR && REG_ADDR == OFS_WORD_LOW) |=> pending_q && BUS_WORD[7:0] == $past(REG_WDATA))
    else $error("word not queued"); // R19
  word_order_a: assert property (@(posedge REF_CLK) disable iff (RESET || DEVICE_RESTART)
    (REG_WR && REG_ADDR == OFS_WORD_LOW) |=> BUS_WORD[15:8] == $past(word_hi_q))
    else $error("high byte misplaced"); // R24
  host_share_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    !bus_cfg_q.host_share |=> ##1 BUS_GRANT != GRANT_HOST || $past(bus_cfg_q.host_share))
    else $error("host granted without share"); // R17
  idle_flag_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    (REG_RD && REG_ADDR == OFS_SEQ_STATE) |=> REG_RDATA[6] == ~|$past(busy))
    else $error("idle flag wrong"); // R14

  word_sent_c: cover property (@(posedge REF_CLK) BUS_WORD_VALID && BUS_WORD_TAKEN);
  restart_c:   cover property (@(posedge REF_CLK) DEVICE_RESTART);
  active_c:    cover property (@(posedge REF_CLK) code[0] == ST_ACTIVE);
endmodule : power_master_unit_ctrl

// ===== bus_taker.sv
// Purpose: Far-side model of the power bus slot that takes queued words.
// Assumes: Word is taken on a rising edge where valid and taken are both high.
// Notes:   Stall lets the bench hold a word pending on purpose.
module bus_taker
  import power_master_unit_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        valid,
  input  wire logic [15:0] word,
  input  wire logic        stall,
  output logic             taken,
  output logic [15:0]      last_word_q,
  output logic [7:0]       count_q
);
  // Accept only when not stalled, so pending can be observed
  assign taken = valid && !stall && !rst;

  always_ff @(posedge clk) begin
    if (rst) begin
      last_word_q <= 16'h0000;
      count_q     <= 8'h00;
    end else if (valid && taken) begin
      last_word_q <= word;
      count_q     <= count_q + 8'h01;
    end
  end
endmodule : bus_taker

// ===== tb_top.sv
// Purpose: Register-level regression of the power state master control.
// Assumes: Short counts set by parameters so restarts fit in a short run.
// Notes:   Reads sample REG_RDATA one edge after the read strobe is taken.
module tb_top;
  import power_master_unit_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, reset, wr, rd, key, vbus, id, usb, slp1, clock_request_input, warm_n, btn_n, system_enable_line;
  logic stall, taken, restart, warm_en, vbus_deb, id_deb, valid;
  logic [1:0]  grant;
  logic [15:0] n_slots;
  logic [7:0]  addr, wdata, rdata, cnt, got;
  logic [15:0] word, seen;
  logic [5:0]  w2p, p2a;
  int          failures, checked;

  power_master_unit_ctrl #(.LONG_PRESS_CYCLES(200), .BUTTON_DEB_CYCLES(2), .DEB_PER_MS(1),
    .SEQ_STEPS(8)) dut_u (.REF_CLK(ref_clk), .RESET(reset), .REG_ADDR(addr),
    .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .CFG_KEY_OPEN(key),
    .VBUS_PIN(vbus), .ID_PIN(id), .USB_PIN(usb), .FIRST_SLEEP_REQUEST(slp1),
    .CLOCK_REQUEST_INPUT(clock_request_input), .WARM_RESET_N(warm_n), .POWER_BUTTON_N(btn_n),
    .SYSTEM_ENABLE_LINE(system_enable_line), .DEVICE_RESTART(restart), .WARM_RESET_ENABLE(warm_en),
    .VBUS_DEBOUNCED(vbus_deb), .ID_DEBOUNCED(id_deb), .BUS_WORD(word), .BUS_WORD_VALID(valid),
    .BUS_WORD_TAKEN(taken), .BUS_GRANT(grant), .W2P_POINTER(w2p), .P2A_POINTER(p2a));
  bus_taker taker_u (.clk(ref_clk), .rst(reset), .valid(valid), .word(word),
    .stall(stall), .taken(taken), .last_word_q(seen), .count_q(cnt));

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic check_val(input string n, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : check_val

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge ref_clk);
    wr    <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a);
    @(posedge ref_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge ref_clk);
    rd   <= 1'b0;
    @(posedge ref_clk);
    got = rdata;
  endtask : rd_reg

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    rd_reg(a);
    check_val($sformatf("reg %h", a), 16'(e), 16'(got));
  endtask : rd_chk

  task automatic wait_restart(input string n, input logic e);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 600 && !hit; i++) begin
      @(posedge ref_clk);
      hit = (restart === 1'b1);
    end
    check_val(n, 16'(e), 16'(hit));
  endtask : wait_restart

  task automatic settle();
    repeat (40) @(posedge ref_clk);
  endtask : settle

  // One extra edge so the grant already reflects the new config
  task automatic count_grant(input logic [1:0] g, output logic [15:0] n);
    n = 16'h0000;
    @(posedge ref_clk);
    repeat (8) begin
      @(posedge ref_clk);
      if (grant === g) n = n + 16'h0001;
    end
  endtask : count_grant

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : tally_and_finish

  initial begin
    {wr, rd, key, vbus, id, usb, clock_request_input, stall} = '0;
    {slp1, warm_n, btn_n, system_enable_line, reset} = '1;
    addr = 8'h00;
    wdata = 8'h00;
    repeat (10) @(posedge ref_clk);
    reset <= 1'b0;
    rd_chk(OFS_WORD_HIGH, 8'hff);
    rd_chk(OFS_WORD_LOW, 8'hff);
    rd_chk(OFS_DEBOUNCE, 8'h02);
    rd_chk(OFS_W2P_POINTER, 8'h00);
    check_val("p2a", 16'h0004, 16'(p2a));
    rd_chk(OFS_P1_EVENTS, 8'h40);
    $display("test reset_values done");
    wr_reg(OFS_DEBOUNCE, 8'h05);
    rd_chk(OFS_DEBOUNCE, 8'h02);
    key <= 1'b1;
    wr_reg(OFS_DEBOUNCE, 8'h00);
    rd_chk(OFS_DEBOUNCE, 8'h00);
    wr_reg(OFS_W2P_POINTER, 8'hff);
    rd_chk(OFS_W2P_POINTER, 8'h3f);
    check_val("w2p", 16'h003f, 16'(w2p));
    $display("test key_lock done");
    wr_reg(OFS_P3_EVENTS, 8'h70);
    rd_chk(OFS_P1_EVENTS, 8'h70);
    check_val("warm_en", 16'h0001, 16'(warm_en));
    wr_reg(OFS_P1_EVENTS, 8'h40);
    $display("test shared_bits done");
    {vbus, id, usb, clock_request_input} <= 4'b1111;
    warm_n <= 1'b0;
    settle();
    rd_reg(OFS_HW_STATUS);
    check_val("status", 16'h00dc, 16'(got));
    check_val("vbus_deb", 16'h0001, 16'(vbus_deb));
    check_val("id_deb", 16'h0001, 16'(id_deb));
    warm_n <= 1'b1;
    $display("test status done");
    wr_reg(OFS_P1_EVENTS, 8'h44);
    rd_reg(OFS_SEQ_STATE);
    check_val("idle", 16'h0000, 16'(got[BIT_IDLE]));
    settle();
    rd_chk(OFS_SEQ_STATE, 8'h41);
    wr_reg(OFS_P1_EVENTS, 8'h42);
    settle();
    rd_chk(OFS_SEQ_STATE, 8'h42);
    wr_reg(OFS_P1_EVENTS, 8'h41);
    settle();
    rd_chk(OFS_SEQ_STATE, 8'h40);
    rd_chk(OFS_P1_EVENTS, 8'h40);
    wr_reg(OFS_P1_EVENTS, 8'h4c);
    settle();
    rd_chk(OFS_SEQ_STATE, 8'h41);
    slp1 <= 1'b0;
    settle();
    rd_chk(OFS_SEQ_STATE, 8'h42);
    slp1 <= 1'b1;
    settle();
    rd_chk(OFS_SEQ_STATE, 8'h41);
    wr_reg(OFS_P1_EVENTS, 8'h40);
    slp1 <= 1'b0;
    settle();
    rd_chk(OFS_SEQ_STATE, 8'h41);
    wr_reg(OFS_P1_EVENTS, 8'h42);
    settle();
    slp1 <= 1'b1;
    settle();
    rd_chk(OFS_SEQ_STATE, 8'h41);
    $display("test sequencers done");
    stall <= 1'b1;
    wr_reg(OFS_BUS_CFG, 8'h02);
    wr_reg(OFS_WORD_HIGH, 8'ha5);
    wr_reg(OFS_WORD_LOW, 8'h3c);
    rd_chk(OFS_BUS_CFG, 8'h03);
    check_val("word", 16'ha53c, word);
    stall <= 1'b0;
    for (int i = 0; i < 100 && cnt == 8'h00; i++) @(posedge ref_clk);
    check_val("taken", 16'ha53c, seen);
    rd_chk(OFS_BUS_CFG, 8'h02);
    count_grant(2'h0, n_slots);
    check_val("host_slots", 16'h0002, n_slots);
    wr_reg(OFS_BUS_CFG, 8'h06);
    count_grant(2'h1, n_slots);
    check_val("owner_slots", 16'h0004, n_slots);
    wr_reg(OFS_BUS_CFG, 8'h04);
    count_grant(2'h3, n_slots);
    check_val("other_slots", 16'h0002, n_slots);
    $display("test bus_word done");
    wr_reg(OFS_P1_EVENTS, 8'h60);
    system_enable_line <= 1'b0;
    wait_restart("sysline", 1'b1);
    system_enable_line <= 1'b1;
    settle();
    rd_chk(OFS_WORD_HIGH, 8'hff);
    btn_n <= 1'b0;
    settle();
    rd_chk(OFS_HW_STATUS, 8'hd5);
    wait_restart("long_press", 1'b1);
    wr_reg(OFS_P1_EVENTS, 8'h00);
    wait_restart("no_long_press", 1'b0);
    btn_n <= 1'b1;
    $display("test restarts done");
    tally_and_finish();
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    tally_and_finish();
  end
endmodule : tb_top
